// file: design/countdown.sv
// Loadable down counter; running while the count is nonzero.
// Same clock and clock enable as the decoder.
`timescale 1ns/1ps
module countdown #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              running
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (ce) begin
      if (load) begin
        cnt <= load_val;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign running = (cnt != '0);
endmodule // countdown

// file: design/dispcmd_top.sv
// Command packet decoder of a character display module: display state, fans, ATX lines.
// Packets arrive framed as bytes on RX_*; answers leave on TX_*; all inputs share CLK.
`timescale 1ns/1ps
`include "dispcmd_cfg.svh"
module dispcmd_top import dispcmd_pkg::*; #(
  parameter int unsigned HOST_RESET_CYC = `HOST_RESET_MS * `CLK_KHZ,
  parameter int unsigned REBOOT_CYC     = `REBOOT_MS * `CLK_KHZ,
  parameter int unsigned FAN_SLOT_CYC   = `FAN_SLOT_MS * `CLK_KHZ
) (
  // Clock, reset, enable
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic             CE,
  // Command bytes in
  input  wire logic             RX_VALID,
  input  wire logic [7:0]       RX_BYTE,
  output logic                  RX_READY,
  // Answer bytes out
  output logic                  TX_VALID,
  output logic [7:0]            TX_BYTE,
  input  wire logic             TX_READY,
  // ATX and USB
  input  wire logic             ATX_DEFAULT_MODE,
  input  wire logic [31:0]      POWER_PULSE_CYC,
  output logic                  HOST_RESET,
  output logic                  HOST_POWER_SW,
  output logic                  USB_DETACH,
  // Display state
  output logic [4:0]            CURSOR_COL,
  output logic [1:0]            CURSOR_ROW,
  output logic [2:0]            CURSOR_STYLE,
  output logic [7:0]            CONTRAST,
  output logic [6:0]            BL_DISPLAY,
  output logic [6:0]            BL_KEYPAD,
  input  wire logic [6:0]       TEXT_RADDR,
  output logic [7:0]            TEXT_RDATA,
  input  wire logic [5:0]       GLYPH_RADDR,
  output logic [5:0]            GLYPH_RDATA,
  // Fans
  input  wire logic [3:0][7:0]  FAN_TACH,
  input  wire logic [3:0][15:0] FAN_TICKS,
  output logic [3:0][6:0]       FAN_POWER
);
  localparam settings_t FACTORY = '{col: 5'h00, row: 2'h0, style: 3'h0,
                                    contrast: `DEF_CONTRAST, bl_disp: `DEF_BKLT,
                                    bl_key: `DEF_BKLT, fan: {4{`DEF_FAN}}};

  resp_if rsp ();

  state_t     state, next_state;
  act_t       act;
  settings_t  live, boot;
  logic [7:0] text [80];
  logic [7:0] boot_text [80];
  logic [5:0] glyph [64];
  logic [5:0] boot_glyph [64];
  logic [7:0] rx_type, rx_len, cnt;
  logic [7:0] rx_data [16];
  logic [3:0] fan_mask;
  logic [1:0] slot, pend_fan;
  logic       fan_pend, soft_kind;
  logic       ok, rsp_free, exec_go, fan_sent, rx_fire, reboot_go;
  logic       hrst_run, hpwr_run, quiet_run, slot_run;
  logic [7:0] rtype, rlen;
  logic [7:0] rdata [9];
  logic [7:0] rd_byte [8];
  logic [5:0] g_idx, c_idx;
  logic [6:0] t_idx;
  logic [23:0] key;

  assign rx_fire   = RX_VALID && RX_READY;
  assign rsp_free  = !rsp.busy && !rsp.start;
  assign exec_go   = (state == S_EXEC) && rsp_free;
  assign fan_sent  = rsp_free && fan_pend && (state != S_EXEC);
  assign reboot_go = (next_state == S_REBOOT) && (state != S_REBOOT);
  assign key       = {rx_data[0], rx_data[1], rx_data[2]};

  // Memory read window, wrapping inside glyph memory, spaces past column 19
  always_comb begin
    g_idx = 6'h00;
    c_idx = 6'h00;
    t_idx = 7'h00;
    for (int i = 0; i < 8; i++) begin
      g_idx = 6'(rx_data[0][5:0] + 6'(i));
      c_idx = 6'({1'b0, rx_data[0][4:0]} + 6'(i));
      t_idx = 7'(7'(rx_data[0][6:5]) * 7'h14 + 7'(c_idx));
      if (!rx_data[0][7]) rd_byte[i] = {2'b00, glyph[g_idx]};
      else if (c_idx <= 6'(`MAX_COL)) rd_byte[i] = text[t_idx];
      else rd_byte[i] = `SPACE_CODE;
    end
  end

  // Command check and answer build
  always_comb begin
    ok   = 1'b0;
    act  = ACT_NONE;
    rlen = 8'h00;
    for (int i = 0; i < 9; i++) rdata[i] = 8'h00;
    case (rx_type)
      `CMD_STORE:  ok = (rx_len == 8'h00);
      `CMD_RESET: begin
        ok = (rx_len == 8'h03);
        case (key)
          `KEY_HRST:   act = ACT_HRST;
          `KEY_HPWR:   act = ACT_HPWR;
          `KEY_SOFT:   act = ACT_SOFT;
          `KEY_FACT:   act = ACT_FACT;
          `KEY_RELOAD: act = ACT_RELOAD;
          default:     ok = 1'b0;
        endcase
        if (!ok) act = ACT_NONE;
      end
      `CMD_CLEAR:  ok = (rx_len == 8'h00);
      `CMD_GLYPH: begin
        ok = (rx_len == 8'h09) && (rx_data[0] < 8'h08);
        for (int k = 1; k < 9; k++) if (rx_data[k][7:6] != 2'b00) ok = 1'b0;
      end
      `CMD_MEMRD: begin
        ok = (rx_len == 8'h01) && (rx_data[0] >= `GLYPH_BASE);
        if (ok) begin
          rlen     = 8'h09;
          rdata[0] = rx_data[0];
          for (int k = 0; k < 8; k++) rdata[k+1] = rd_byte[k];
        end
      end
      `CMD_CURPOS: ok = (rx_len == 8'h02) && (rx_data[0] <= 8'(`MAX_COL))
                        && (rx_data[1] < 8'h04);
      `CMD_CURSTY: ok = (rx_len == 8'h01) && (rx_data[0] <= `MAX_STYLE);
      `CMD_CONTR:  ok = (rx_len == 8'h01);
      `CMD_BKLT:   ok = ((rx_len == 8'h01) || (rx_len == 8'h02)) && (rx_data[0] <= `MAX_LEVEL)
                        && ((rx_len == 8'h01) || (rx_data[1] <= `MAX_LEVEL));
      `CMD_FANRPT: ok = (rx_len == 8'h01) && (rx_data[0] < 8'h10);
      `CMD_FANPWR: begin
        ok = (rx_len == 8'h04);
        for (int k = 0; k < 4; k++) if (rx_data[k] > `MAX_LEVEL) ok = 1'b0;
      end
      default:     ok = 1'b0;
    endcase
    rtype = {(ok ? `RSP_OK : `RSP_ERR), rx_type[5:0]};
  end

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:   if (rx_fire) next_state = S_LEN;
      S_LEN:    if (rx_fire) next_state = (RX_BYTE == 8'h00) ? S_EXEC : S_DATA;
      S_DATA:   if (rx_fire && (cnt == 8'(rx_len - 8'h01))) next_state = S_EXEC;
      S_EXEC: begin
        if (exec_go) begin
          case (act)
            ACT_HRST:           next_state = S_HRST;
            ACT_HPWR:           next_state = S_HPWR;
            ACT_SOFT, ACT_FACT: next_state = S_REBOOT;
            default:            next_state = S_IDLE;
          endcase
        end
      end
      S_HRST:   if (!hrst_run) next_state = S_REBOOT;
      S_HPWR:   if (!hpwr_run) next_state = S_REBOOT;
      S_REBOOT: if (!quiet_run) next_state = S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state    <= S_IDLE;
      RX_READY <= 1'b0;
    end else if (CE) begin
      state    <= next_state;
      RX_READY <= (next_state == S_IDLE) || (next_state == S_LEN) || (next_state == S_DATA);
    end
  end

  // Packet capture; bytes beyond sixteen are dropped
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_type <= 8'h00;
      rx_len  <= 8'h00;
      cnt     <= 8'h00;
      for (int i = 0; i < 16; i++) rx_data[i] <= 8'h00;
    end else if (CE && rx_fire) begin
      case (state)
        S_IDLE: rx_type <= RX_BYTE;
        S_LEN: begin
          rx_len <= RX_BYTE;
          cnt    <= 8'h00;
        end
        default: begin
          if (cnt < 8'h10) rx_data[cnt[3:0]] <= RX_BYTE;
          cnt <= cnt + 8'h01;
        end
      endcase
    end
  end

  // Answer and fan report issue
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rsp.start <= 1'b0;
      rsp.ptype <= 8'h00;
      rsp.plen  <= 8'h00;
      for (int i = 0; i < 9; i++) rsp.pdata[i] <= 8'h00;
    end else if (CE) begin
      rsp.start <= exec_go || fan_sent;
      if (exec_go) begin
        rsp.ptype <= rtype;
        rsp.plen  <= rlen;
        rsp.pdata <= rdata;
      end else if (fan_sent) begin
        rsp.ptype    <= `RPT_FAN;
        rsp.plen     <= `FAN_RPT_LEN;
        rsp.pdata[0] <= {6'h00, pend_fan};
        rsp.pdata[1] <= FAN_TACH[pend_fan];
        rsp.pdata[2] <= FAN_TICKS[pend_fan][7:0];
        rsp.pdata[3] <= FAN_TICKS[pend_fan][15:8];
      end
    end
  end

  // Live display and fan settings
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      live     <= FACTORY;
      fan_mask <= 4'h0;
      for (int i = 0; i < 80; i++) text[i] <= `SPACE_CODE;
      for (int i = 0; i < 64; i++) glyph[i] <= 6'h00;
    end else if (CE) begin
      if (exec_go && act == ACT_FACT) begin
        live     <= FACTORY;
        fan_mask <= 4'h0;
        for (int i = 0; i < 80; i++) text[i] <= `SPACE_CODE;
        for (int i = 0; i < 64; i++) glyph[i] <= 6'h00;
      end else if (reboot_go || (exec_go && act == ACT_RELOAD)) begin
        live <= boot;
        text <= boot_text;
        glyph <= boot_glyph;
        if (reboot_go) fan_mask <= 4'h0;
      end else if (exec_go && ok) begin
        case (rx_type)
          `CMD_CLEAR: begin
            for (int i = 0; i < 80; i++) text[i] <= `SPACE_CODE;
            live.col <= 5'h00;
            live.row <= 2'h0;
          end
          `CMD_GLYPH:
            for (int k = 0; k < 8; k++) glyph[{rx_data[0][2:0], 3'(k)}] <= rx_data[k+1][5:0];
          `CMD_CURPOS: begin
            live.col <= rx_data[0][4:0];
            live.row <= rx_data[1][1:0];
          end
          `CMD_CURSTY: live.style <= rx_data[0][2:0];
          `CMD_CONTR:  live.contrast <= rx_data[0];
          `CMD_BKLT: begin
            live.bl_disp <= rx_data[0][6:0];
            live.bl_key  <= (rx_len == 8'h02) ? rx_data[1][6:0] : rx_data[0][6:0];
          end
          `CMD_FANRPT: fan_mask <= rx_data[0][3:0];
          `CMD_FANPWR: for (int k = 0; k < 4; k++) live.fan[k] <= rx_data[k][6:0];
          default: ;
        endcase
      end
    end
  end

  // Boot state store and factory restore
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot <= FACTORY;
      for (int i = 0; i < 80; i++) boot_text[i] <= `SPACE_CODE;
      for (int i = 0; i < 64; i++) boot_glyph[i] <= 6'h00;
    end else if (CE && exec_go) begin
      if (ok && rx_type == `CMD_STORE) begin
        boot       <= live;
        boot_text  <= text;
        boot_glyph <= glyph;
      end else if (act == ACT_FACT) begin
        boot <= FACTORY;
        for (int i = 0; i < 80; i++) boot_text[i] <= `SPACE_CODE;
        for (int i = 0; i < 64; i++) boot_glyph[i] <= 6'h00;
      end
    end
  end

  countdown #(.W(32)) u_hrst (.clk(CLK), .arst_n(ARST_N), .ce(CE),
    .load(exec_go && act == ACT_HRST), .load_val(HOST_RESET_CYC), .running(hrst_run));
  countdown #(.W(32)) u_hpwr (.clk(CLK), .arst_n(ARST_N), .ce(CE),
    .load(exec_go && act == ACT_HPWR), .load_val(POWER_PULSE_CYC), .running(hpwr_run));
  countdown #(.W(32)) u_quiet (.clk(CLK), .arst_n(ARST_N), .ce(CE),
    .load(reboot_go), .load_val(REBOOT_CYC), .running(quiet_run));
  countdown #(.W(32)) u_slot (.clk(CLK), .arst_n(ARST_N), .ce(CE),
    .load(!slot_run), .load_val(FAN_SLOT_CYC - 32'h1), .running(slot_run));

  // ATX lines and USB detach; lines driven only in default drive mode
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_RESET    <= 1'b0;
      HOST_POWER_SW <= 1'b0;
      USB_DETACH    <= 1'b0;
      soft_kind     <= 1'b0;
    end else if (CE) begin
      HOST_RESET    <= (next_state == S_HRST) && ATX_DEFAULT_MODE;
      HOST_POWER_SW <= (next_state == S_HPWR) && ATX_DEFAULT_MODE;
      if (exec_go) soft_kind <= (act == ACT_SOFT) || (act == ACT_FACT);
      USB_DETACH    <= (next_state == S_REBOOT) && (exec_go ? (act == ACT_SOFT || act == ACT_FACT)
                                                            : soft_kind);
    end
  end

  // Fan slots of 1/8 s, reports and full-power override
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slot      <= 2'h0;
      fan_pend  <= 1'b0;
      pend_fan  <= 2'h0;
      FAN_POWER <= {4{`DEF_FAN}};
    end else if (CE) begin
      if (!slot_run) slot <= slot + 2'h1;
      if (!slot_run && fan_mask[2'(slot + 2'h1)]) begin
        fan_pend <= 1'b1;
        pend_fan <= slot + 2'h1;
      end else if (fan_sent) begin
        fan_pend <= 1'b0;
      end
      for (int i = 0; i < 4; i++)
        FAN_POWER[i] <= (fan_mask[slot] && slot == 2'(i)) ? `FULL_POWER : live.fan[i];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TEXT_RDATA  <= `SPACE_CODE;
      GLYPH_RDATA <= 6'h00;
    end else if (CE) begin
      TEXT_RDATA  <= (TEXT_RADDR < 7'h50) ? text[TEXT_RADDR] : `SPACE_CODE;
      GLYPH_RDATA <= glyph[GLYPH_RADDR];
    end
  end

  assign CURSOR_COL   = live.col;
  assign CURSOR_ROW   = live.row;
  assign CURSOR_STYLE = live.style;
  assign CONTRAST     = live.contrast;
  assign BL_DISPLAY   = live.bl_disp;
  assign BL_KEYPAD    = live.bl_key;

  resp_serializer u_ser (.clk(CLK), .arst_n(ARST_N), .ce(CE), .rsp(rsp.snk),
    .tx_valid(TX_VALID), .tx_byte(TX_BYTE), .tx_ready(TX_READY));

  property p_low6;
    @(posedge CLK) disable iff (!ARST_N) exec_go && CE |=> rsp.ptype[5:0] == rx_type[5:0];
  endproperty
  a_low6: assert property (p_low6) else $error("answer type lost command code");
  property p_ack45;
    @(posedge CLK) disable iff (!ARST_N)
      exec_go && CE && ok && rx_type == `CMD_RESET |=> rsp.ptype == 8'h45 && rsp.plen == 8'h00;
  endproperty
  a_ack45: assert property (p_ack45) else $error("reset ack not 0x45 length 0");
  property p_badkey;
    @(posedge CLK) disable iff (!ARST_N)
      exec_go && CE && rx_type == `CMD_RESET && !ok |=> rsp.ptype == 8'hC5 && state == S_IDLE;
  endproperty
  a_badkey: assert property (p_badkey) else $error("bad reset key not refused");
  property p_hrst;
    @(posedge CLK) disable iff (!ARST_N)
      exec_go && CE && act == ACT_HRST && ATX_DEFAULT_MODE |=> HOST_RESET;
  endproperty
  a_hrst: assert property (p_hrst) else $error("host reset not pulsed");
  property p_reboot;
    @(posedge CLK) disable iff (!ARST_N) state == S_HRST && !hrst_run && CE |=> state == S_REBOOT;
  endproperty
  a_reboot: assert property (p_reboot) else $error("no reboot after host reset");
  property p_quiet;
    @(posedge CLK) disable iff (!ARST_N)
      state == S_REBOOT && $past(state) == S_REBOOT |-> !RX_READY;
  endproperty
  a_quiet: assert property (p_quiet) else $error("commands taken during reboot");
  property p_clear;
    @(posedge CLK) disable iff (!ARST_N) exec_go && CE && ok && rx_type == `CMD_CLEAR
      |=> text[0] == `SPACE_CODE && text[79] == `SPACE_CODE && CURSOR_COL == 5'h00
          && CURSOR_ROW == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear screen incomplete");
  property p_col;
    @(posedge CLK) disable iff (!ARST_N)
      exec_go && CE && rx_type == `CMD_CURPOS && rx_data[0] > 8'h13 |=> rsp.ptype[7:6] == 2'h3;
  endproperty
  a_col: assert property (p_col) else $error("bad column accepted");
  property p_boost;
    @(posedge CLK) disable iff (!ARST_N) fan_mask[slot] && CE |=> FAN_POWER[$past(slot)] == 7'h64;
  endproperty
  a_boost: assert property (p_boost) else $error("reported fan not at full power");
endmodule // dispcmd_top

// file: design/resp_serializer.sv
// Sends an answer packet byte by byte: type, length, then data.
// The sink takes a byte on TX_VALID and TX_READY both high.
`timescale 1ns/1ps
module resp_serializer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Packet from decoder
  resp_if.snk             rsp,
  // Byte stream out
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  input  wire logic       tx_ready
);
  logic [7:0] len;
  logic [7:0] dat [9];
  logic [3:0] idx;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp.busy <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      len      <= 8'h00;
      idx      <= 4'h0;
      for (int i = 0; i < 9; i++) dat[i] <= 8'h00;
    end else if (ce) begin
      if (!rsp.busy) begin
        if (rsp.start) begin
          rsp.busy <= 1'b1;
          tx_valid <= 1'b1;
          tx_byte  <= rsp.ptype;
          len      <= rsp.plen;
          dat      <= rsp.pdata;
          idx      <= 4'h1;
        end
      end else if (tx_valid && tx_ready) begin
        if (idx == 4'(len) + 4'h2) begin
          rsp.busy <= 1'b0;
          tx_valid <= 1'b0;
        end else begin
          tx_byte <= (idx == 4'h1) ? len : dat[4'(idx - 4'h2)];
          idx     <= idx + 4'h1;
        end
      end
    end
  end
endmodule // resp_serializer

// file: shared/dispcmd_cfg.svh
// Constants of the display module command decoder: codes, keys, reset values, times.
// Assumes packets arrive already framed (type, length, data); checksums are handled outside.
// Overview of operation
// - Every command gets one answer; low six bits kept, bit 6 set on success.
// - Reset key 12,28,97: answer issued at the same edge that raises the host reset line.
// - Host reset lasts about 1.5 s, then reboot; commands ignored up to 3 s.
// - Host reset drives the pin 3 line, host power-off the pin 2 line.
// - Key 3,11,95: acknowledge, power cycle host, reboot, quiet up to 3 s.
// - Host power cycle length follows the configured power pulse length.
// - Key 8,25,48: acknowledge, soft reboot, ignore commands up to 3 s.
// - Soft reboot detaches from USB and reattaches so enumeration repeats.
// - Key 10,8,98: restore factory boot state and start soft reboot at the edge the answer is issued.
// - Successful reset sub-functions answer type 0x45 with zero data length.
// - Clear screen fills text memory with spaces and homes the cursor.
// - Glyph write: index 0..7 and eight 6-bit rows, top row first.
// - Memory read takes controller address, returns address plus eight bytes.
// - Cursor position: column 0..19 then row 0..3.
// - Cursor style codes 0..4: none, block, underscore, both, blinking underscore.
// - Contrast takes any byte 0..255, larger is darker.
// - One backlight byte 0..100 sets display and keypad backlights together.
// - Two backlight bytes: first to display, second to keypad.
// - Fan reporting mask 0..15, fan 1 in bit 0, off after power-on.
// - Nonzero mask: each enabled fan reported every 500 ms, staggered by 1/8 s.
// - Reported fan forced to full power up to 1/8 s per half second.
// - Fan power command: four levels 0..100 for fans 1 to 4.
// - Glyphs, cursor, contrast, backlights and fan power are saved as boot state.
`ifndef DISPCMD_CFG_SVH
`define DISPCMD_CFG_SVH

`define CMD_STORE    8'h04
`define CMD_RESET    8'h05
`define CMD_CLEAR    8'h06
`define CMD_GLYPH    8'h09
`define CMD_MEMRD    8'h0A
`define CMD_CURPOS   8'h0B
`define CMD_CURSTY   8'h0C
`define CMD_CONTR    8'h0D
`define CMD_BKLT     8'h0E
`define CMD_FANRPT   8'h10
`define CMD_FANPWR   8'h11
`define RPT_FAN      8'h81

`define RSP_OK       2'h1
`define RSP_ERR      2'h3

`define KEY_HRST     24'h0C_1C61
`define KEY_HPWR     24'h03_0B5F
`define KEY_SOFT     24'h08_1930
`define KEY_FACT     24'h0A_0862
`define KEY_RELOAD   24'h08_1263

`define SPACE_CODE   8'h20
`define GLYPH_BASE   8'h40
`define MAX_COL      5'h13
`define MAX_STYLE    8'h04
`define FULL_POWER   7'h64
`define MAX_LEVEL    8'h64
`define FAN_RPT_LEN  8'h04

`define DEF_CONTRAST 8'h55
`define DEF_BKLT     7'h64
`define DEF_FAN      7'h64

`define CLK_KHZ      100000
`define HOST_RESET_MS 1500
`define REBOOT_MS    3000
`define FAN_SLOT_MS  125

`endif

// file: shared/dispcmd_pkg.sv
// Types of the display module command decoder.
// Constants live in dispcmd_cfg.svh.
package dispcmd_pkg;
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_LEN    = 3'b001,
    S_DATA   = 3'b010,
    S_EXEC   = 3'b011,
    S_HRST   = 3'b100,
    S_HPWR   = 3'b101,
    S_REBOOT = 3'b110
  } state_t;
  typedef enum logic [2:0] {
    ACT_NONE   = 3'b000,
    ACT_HRST   = 3'b001,
    ACT_HPWR   = 3'b010,
    ACT_SOFT   = 3'b011,
    ACT_FACT   = 3'b100,
    ACT_RELOAD = 3'b101
  } act_t;
  typedef struct packed {
    logic [4:0]      col;
    logic [1:0]      row;
    logic [2:0]      style;
    logic [7:0]      contrast;
    logic [6:0]      bl_disp;
    logic [6:0]      bl_key;
    logic [3:0][6:0] fan;
  } settings_t;
endpackage

// file: shared/resp_if.sv
// Answer packet handed from the decoder to the byte serializer.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface resp_if;
  logic       start;
  logic       busy;
  logic [7:0] ptype;
  logic [7:0] plen;
  logic [7:0] pdata [9];
  modport src (output start, ptype, plen, pdata, input busy);
  modport snk (input start, ptype, plen, pdata, output busy);
endinterface

// file: verif/dispcmd_top_bench.sv
// Self-checking bench of the command decoder: command packets in, answers checked.
// Assumes short reset and slot counts set by parameter below.
`timescale 1ns/1ps
module dispcmd_top_bench;
  logic clk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, slow;
  logic [7:0] rx_byte, tx_byte, contrast, text_rdata;
  logic host_reset, host_power_sw, usb_detach;
  logic ce, atx;
  logic [4:0] cur_col;
  logic [1:0] cur_row;
  logic [2:0] cur_style;
  logic [6:0] bl_disp, bl_key;
  logic [5:0] glyph_raddr, glyph_rdata;
  logic [3:0][6:0] fan_power;
  int errors = 0;
  int n_compared = 0;
  dispcmd_top #(.HOST_RESET_CYC(20), .REBOOT_CYC(40), .FAN_SLOT_CYC(16)) dut (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_READY(tx_ready),
    .ATX_DEFAULT_MODE(atx), .POWER_PULSE_CYC(32'h0000_0008), .HOST_RESET(host_reset),
    .HOST_POWER_SW(host_power_sw), .USB_DETACH(usb_detach), .CURSOR_COL(cur_col),
    .CURSOR_ROW(cur_row), .CURSOR_STYLE(cur_style), .CONTRAST(contrast),
    .BL_DISPLAY(bl_disp), .BL_KEYPAD(bl_key), .TEXT_RADDR(7'h00), .TEXT_RDATA(text_rdata),
    .GLYPH_RADDR(glyph_raddr), .GLYPH_RDATA(glyph_rdata), .FAN_TACH({4{8'h2A}}),
    .FAN_TICKS({4{16'h1234}}), .FAN_POWER(fan_power));
  host_link_model host (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Byte held until taken at an edge with ready high
  task send(input logic [7:0] b[$]);
    @(posedge clk);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_byte  <= b[i];
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
    end
    rx_valid <= 1'b0;
  endtask
  task exp_pkt(input logic [7:0] t, input logic [7:0] len);
    for (int i = 0; i < 300 && host.q.size() < 2; i++) @(posedge clk);
    chk(host.q.size() >= 2, 1);
    if (host.q.size() >= 2) begin
      chk(host.q.pop_front(), t);
      chk(host.q.pop_front(), len);
    end
  endtask
  task exp_byte(input logic [7:0] d);
    for (int i = 0; i < 20 && host.q.size() == 0; i++) @(posedge clk);
    chk(host.q.size() > 0, 1);
    if (host.q.size() > 0) chk(host.q.pop_front(), d);
  endtask
  task wait_rdy;
    for (int i = 0; i < 400 && rx_ready !== 1'b1; i++) @(posedge clk);
  endtask
  initial begin
    #100000;
    errors++;
    close_out();
  end
  initial begin
    arst_n = 1'b0; rx_valid = 1'b0; rx_byte = 8'h00; slow = 1'b0; glyph_raddr = 6'h00;
    ce  = 1'b1;
    atx = 1'b1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    send('{8'h0B, 8'h02, 8'h13, 8'h03}); exp_pkt(8'h4B, 8'h00);
    chk({cur_col, cur_row}, {5'h13, 2'h3});
    send('{8'h0B, 8'h02, 8'h14, 8'h00}); exp_pkt(8'hCB, 8'h00);
    send('{8'h06, 8'h00}); exp_pkt(8'h46, 8'h00);
    chk({cur_col, cur_row, text_rdata}, {7'h00, 8'h20});
    for (int s = 0; s < 5; s++) begin
      send('{8'h0C, 8'h01, 8'(s)}); exp_pkt(8'h4C, 8'h00); chk(cur_style, s);
    end
    slow <= 1'b1;
    send('{8'h0E, 8'h01, 8'h32}); exp_pkt(8'h4E, 8'h00); chk({bl_disp, bl_key}, {7'h32, 7'h32});
    send('{8'h0E, 8'h02, 8'h0A, 8'h14}); exp_pkt(8'h4E, 8'h00);
    chk({bl_disp, bl_key}, {7'h0A, 7'h14});
    slow <= 1'b0;
    send('{8'h11, 8'h04, 8'h00, 8'h21, 8'h42, 8'h64}); exp_pkt(8'h51, 8'h00);
    chk(fan_power, {7'h64, 7'h42, 7'h21, 7'h00});
    send('{8'h09, 8'h09, 8'h07, 8'h3F, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
    exp_pkt(8'h49, 8'h00); glyph_raddr <= 6'h38;
    repeat (2) @(posedge clk); chk(glyph_rdata, 6'h3F);
    send('{8'h0A, 8'h01, 8'h78}); exp_pkt(8'h4A, 8'h09); exp_byte(8'h78);
    exp_byte(8'h3F);
    for (int r = 1; r < 8; r++) exp_byte(8'(r));
    send('{8'h0A, 8'h01, 8'h3F}); exp_pkt(8'hCA, 8'h00);
    send('{8'h05, 8'h03, 8'h01, 8'h02, 8'h03}); exp_pkt(8'hC5, 8'h00);
    chk({host_reset, host_power_sw, usb_detach}, 0);
    send('{8'h0D, 8'h01, 8'hFF}); exp_pkt(8'h4D, 8'h00); chk(contrast, 8'hFF);
    send('{8'h05, 8'h03, 8'h0C, 8'h1C, 8'h61}); exp_pkt(8'h45, 8'h00);
    chk({host_reset, rx_ready}, 2'b10);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    chk(host_reset, 1);
    ce <= 1'b1;
    wait_rdy(); chk(contrast, 8'h55);
    send('{8'h05, 8'h03, 8'h03, 8'h0B, 8'h5F}); exp_pkt(8'h45, 8'h00);
    chk(host_power_sw, 1);
    wait_rdy();
    send('{8'h0D, 8'h01, 8'hFF}); exp_pkt(8'h4D, 8'h00);
    send('{8'h04, 8'h00}); exp_pkt(8'h44, 8'h00);
    send('{8'h0D, 8'h01, 8'h10}); exp_pkt(8'h4D, 8'h00);
    send('{8'h05, 8'h03, 8'h08, 8'h12, 8'h63}); exp_pkt(8'h45, 8'h00);
    chk({contrast, rx_ready}, {8'hFF, 1'b1});
    send('{8'h05, 8'h03, 8'h08, 8'h19, 8'h30}); exp_pkt(8'h45, 8'h00);
    chk({usb_detach, rx_ready}, 2'b10);
    wait_rdy(); chk(contrast, 8'hFF);
    send('{8'h05, 8'h03, 8'h0A, 8'h08, 8'h62}); exp_pkt(8'h45, 8'h00);
    wait_rdy(); chk(contrast, 8'h55);
    atx <= 1'b0;
    send('{8'h05, 8'h03, 8'h0C, 8'h1C, 8'h61}); exp_pkt(8'h45, 8'h00);
    chk({host_reset, rx_ready}, 2'b00);
    wait_rdy();
    atx <= 1'b1;
    send('{8'h11, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}); exp_pkt(8'h51, 8'h00);
    send('{8'h10, 8'h01, 8'h01}); exp_pkt(8'h50, 8'h00);
    exp_pkt(8'h81, 8'h04);
    chk(fan_power, {7'h00, 7'h00, 7'h00, 7'h64});
    exp_byte(8'h00); exp_byte(8'h2A);
    exp_byte(8'h34); exp_byte(8'h12);
    close_out();
  end
endmodule // dispcmd_top_bench

// file: verif/host_link_model.sv
// Host side of the answer stream: takes answer bytes into a queue.
// Assumes one clock shared with the decoder; slow halves the accept rate.
`timescale 1ns/1ps
module host_link_model (
  // Clock and pace
  input  wire logic       clk,
  input  wire logic       slow,
  // Answer bytes
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  logic [7:0] q[$];
  logic       ph = 1'b0;
  assign tx_ready = !slow || ph;
  always @(posedge clk) begin
    ph <= ~ph;
    if (tx_valid && tx_ready) begin
      q.push_back(tx_byte);
    end
  end
endmodule // host_link_model
